// ### dasm_regs.sv
// status, mode, result and coefficient registers for two sigma-delta converters
`timescale 1ns/1ps
module dasm_regs (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata_q,
   input wire dasm_pkg::dasm_ev_t [1:0] conv_ev,
   input wire logic ref_missing,
   input wire logic ext_ref_sel,
   output dasm_pkg::dasm_ctrl_t [1:0] conv_ctrl
);
   logic [7:0] mode_q;
   logic [7:0] decim_q;
   logic [1:0] rdy_q;
   logic [1:0] err_q;
   logic cal_q;
   logic noref_q;
   logic [1:0] start_q;
   logic [1:0] hold_q;
   logic [1:0][15:0] res_q;
   logic [1:0][15:0] off_q;
   logic [1:0][15:0] gn_q;
   logic [7:0] status;
   logic [7:0] rdata_d;
   logic mode_wr;
   logic stat_wr;
   logic start_cmd;
   logic [1:0] en;
   logic [1:0] start_ch;
   logic [1:0] running;
   logic [1:0] accept;
   logic [1:0] acc_conv;
   logic [1:0] acc_cal;
   logic active;
   logic force_ones;
   dasm_pkg::dasm_md_t md;

   // decode of bus writes and the current mode
   assign mode_wr = sfr_wr && (sfr_addr == dasm_pkg::A_MODE);
   assign stat_wr = sfr_wr && (sfr_addr == dasm_pkg::A_STAT);
   assign md = dasm_pkg::dasm_md_t'(mode_q[2:0]);
   assign en = {mode_q[dasm_pkg::M_EN1], mode_q[dasm_pkg::M_EN0]};
   assign start_cmd = mode_wr && (sfr_wdata[2:0] == dasm_pkg::DASM_MD_SINGLE
      || sfr_wdata[2:0] == dasm_pkg::DASM_MD_CONT
      || sfr_wdata[2:0] == dasm_pkg::DASM_MD_ZCAL);
   assign start_ch = {2{start_cmd}}
      & {sfr_wdata[dasm_pkg::M_EN1], sfr_wdata[dasm_pkg::M_EN0]};
   assign active = |(en & {2{md != dasm_pkg::DASM_MD_PWRDN}});
   assign force_ones = noref_q && ext_ref_sel;

   // per converter acceptance of a finished cycle
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         running[c] = en[c] && (md == dasm_pkg::DASM_MD_SINGLE
            || md == dasm_pkg::DASM_MD_CONT || md == dasm_pkg::DASM_MD_ZCAL);
         // a ready flag still set inhibits the write entirely
         accept[c] = running[c] && !rdy_q[c]
            && (conv_ev[c].conv_done || conv_ev[c].cal_done);
         acc_conv[c] = accept[c] && conv_ev[c].conv_done
            && md != dasm_pkg::DASM_MD_ZCAL;
         acc_cal[c] = accept[c] && conv_ev[c].cal_done
            && md == dasm_pkg::DASM_MD_ZCAL;
      end
   end

   // ready flags: set wins over either kind of clear
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rdy_q <= 2'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (accept[c]) begin
               rdy_q[c] <= 1'b1;
            end else if (start_ch[c]) begin
               rdy_q[c] <= 1'b0;
            end else if (stat_wr && !sfr_wdata[dasm_pkg::ST_PRIMARY_READY_FLAG - c]) begin
               rdy_q[c] <= 1'b0;
            end
         end
      end
   end

   // clamp and calibration error flags
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         err_q <= 2'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (acc_conv[c] && (conv_ev[c].clamped || force_ones)) begin
               err_q[c] <= 1'b1;
            end else if (acc_cal[c] && conv_ev[c].cal_fault) begin
               err_q[c] <= 1'b1;
            end else if (start_ch[c]) begin
               err_q[c] <= 1'b0;
            end
         end
      end
   end

   // calibration complete flag, software cannot clear it directly
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cal_q <= 1'b0;
      end else if (|acc_cal) begin
         cal_q <= 1'b1;
      end else if (start_cmd) begin
         cal_q <= 1'b0;
      end
   end

   // reference detect, sampled only while a converter is enabled outside power-down
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         noref_q <= 1'b0;
      end else begin
         noref_q <= active && ref_missing;
      end
   end

   // conversion results, forced high on a lost external reference
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         res_q <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (acc_conv[c]) begin
               res_q[c] <= force_ones ? dasm_pkg::ALL_ONES : conv_ev[c].data;
            end
         end
      end
   end

   // offset coefficients: calibration result or software bytes
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         off_q <= {2{dasm_pkg::OFF_RST}};
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (acc_cal[c] && !conv_ev[c].cal_fault) begin
               off_q[c] <= conv_ev[c].data;
            end else if (sfr_wr && sfr_addr == dasm_pkg::A_OFF_HI[c]) begin
               off_q[c][15:8] <= sfr_wdata;
            end else if (sfr_wr && sfr_addr == dasm_pkg::A_OFF_LO[c]) begin
               off_q[c][7:0] <= sfr_wdata;
            end
         end
      end
   end

   // gain coefficients, software owned since only zero-scale is calibrated here
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         gn_q <= {2{dasm_pkg::GN_RST}};
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (sfr_wr && sfr_addr == dasm_pkg::A_GN_HI[c]) begin
               gn_q[c][15:8] <= sfr_wdata;
            end else if (sfr_wr && sfr_addr == dasm_pkg::A_GN_LO[c]) begin
               gn_q[c][7:0] <= sfr_wdata;
            end
         end
      end
   end

   // mode register; single conversion drops back to power-down
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         mode_q <= dasm_pkg::MODE_RST;
      end else if (mode_wr) begin
         mode_q <= sfr_wdata & dasm_pkg::MODE_WMASK;
      end else if (|acc_conv && md == dasm_pkg::DASM_MD_SINGLE) begin
         mode_q[2:0] <= dasm_pkg::DASM_MD_PWRDN;
      end
   end

   // decimation factor shared by both filters
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         decim_q <= dasm_pkg::DECIM_RST;
      end else if (sfr_wr && sfr_addr == dasm_pkg::A_DECIM) begin
         decim_q <= sfr_wdata;
      end
   end

   // one-cycle start pulse towards each launched converter
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         start_q <= 2'h0;
      end else begin
         start_q <= start_ch;
      end
   end

   // idle hold registered, so the steering output leaves a flip-flop
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         hold_q <= 2'h0;
      end else begin
         hold_q <= en & {2{md == dasm_pkg::DASM_MD_IDLE}};
      end
   end

   // status image, reserved low bits tied to zero
   assign status = {rdy_q[0], rdy_q[1], cal_q, noref_q, err_q[0], err_q[1], 2'h0};

   // read mux, unmapped addresses answer zero
   always_comb begin
      rdata_d = 8'h00;
      if (sfr_addr == dasm_pkg::A_STAT) begin
         rdata_d = status;
      end else if (sfr_addr == dasm_pkg::A_MODE) begin
         rdata_d = mode_q;
      end else if (sfr_addr == dasm_pkg::A_DECIM) begin
         rdata_d = decim_q;
      end
      for (int c = 0; c < 2; c++) begin
         if (sfr_addr == dasm_pkg::A_RES_HI[c]) rdata_d = res_q[c][15:8];
         if (sfr_addr == dasm_pkg::A_RES_LO[c]) rdata_d = res_q[c][7:0];
         if (sfr_addr == dasm_pkg::A_OFF_HI[c]) rdata_d = off_q[c][15:8];
         if (sfr_addr == dasm_pkg::A_OFF_LO[c]) rdata_d = off_q[c][7:0];
         if (sfr_addr == dasm_pkg::A_GN_HI[c]) rdata_d = gn_q[c][15:8];
         if (sfr_addr == dasm_pkg::A_GN_LO[c]) rdata_d = gn_q[c][7:0];
      end
   end

   // read data registered, held between reads
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sfr_rdata_q <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata_q <= rdata_d;
      end
   end

   // converter steering, every field taken from a flip-flop
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         conv_ctrl[c].enable = en[c];
         conv_ctrl[c].mode = mode_q[2:0];
         conv_ctrl[c].hold_reset = hold_q[c];
         conv_ctrl[c].start = start_q[c];
         conv_ctrl[c].decim = decim_q;
         conv_ctrl[c].offset = off_q[c];
         conv_ctrl[c].gain = gn_q[c];
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_launch(int c);
      start_ch[c] && !accept[c];
   endsequence
   sequence s_single_done;
      |acc_conv && md == dasm_pkg::DASM_MD_SINGLE && !mode_wr;
   endsequence

   // flag set and clear paths
   a_ready_set: assert property (accept[0] |=> status[7])
      else $error("primary ready not set after finished cycle");
   a_ready_clear: assert property (s_launch(0) |=> !status[7])
      else $error("primary ready not cleared by start");
   a_result_hold: assert property (rdy_q[0] |=> $stable(res_q[0]))
      else $error("primary result changed while ready set");
   a_aux_hold: assert property (rdy_q[1] && !stat_wr && !start_ch[1]
      |=> rdy_q[1] && $stable(res_q[1]))
      else $error("auxiliary ready or result disturbed");
   a_aux_ready: assert property (accept[1] |=> status[6])
      else $error("auxiliary ready not set after finished cycle");
   a_cal_flag: assert property (|acc_cal |=> status[5])
      else $error("calibration flag not set");
   a_cal_clear: assert property (start_cmd && !(|acc_cal) |=> !status[5])
      else $error("calibration flag survived a start");
   // error and reference reporting
   a_noref_level: assert property (active && ref_missing |=> status[4])
      else $error("missing reference not flagged");
   a_force_ones: assert property (acc_conv[0] && force_ones |=> res_q[0] == 16'hffff)
      else $error("result not forced to all ones");
   a_err_clamp: assert property (acc_conv[0] && conv_ev[0].clamped |=> status[3])
      else $error("clamp did not set primary error");
   a_err_start: assert property (s_launch(0) |=> !status[3])
      else $error("primary error not cleared by start");
   a_cal_fault: assert property (acc_cal[1] && conv_ev[1].cal_fault
      |=> status[2] && $stable(off_q[1]))
      else $error("failed calibration not reported or offset changed");
   a_err_clear: assert property (s_launch(1) |=> !status[2])
      else $error("auxiliary error not cleared by start");
   // mode register side effects, steering and reserved status bits
   a_single_stop: assert property (s_single_done |=> mode_q[2:0] == 3'h0 && !start_q[0])
      else $error("single conversion did not return to power-down");
   a_start_pulse: assert property (start_ch[0] |=> conv_ctrl[0].start)
      else $error("primary start pulse missing");
   a_idle_hold: assert property (en[0] && md == dasm_pkg::DASM_MD_IDLE
      |=> conv_ctrl[0].hold_reset)
      else $error("idle hold not raised");
   a_mode_mask: assert property (mode_wr |=> mode_q[7:6] == 2'h0 && !mode_q[3])
      else $error("reserved mode bit stored");
   a_rsv_read: assert property (sfr_rd && sfr_addr == dasm_pkg::A_STAT |=> sfr_rdata_q[1:0] == 2'h0)
      else $error("reserved status bits read nonzero");
endmodule

// ### dasm_pkg.sv
// constants, types and field layout for the dual converter status and mode registers
package dasm_pkg;
   // register addresses on the special function register bus
   localparam logic [7:0] A_MODE = 8'hd1;
   localparam logic [7:0] A_STAT = 8'hd8;
   localparam logic [7:0] A_DECIM = 8'hd5;
   // per converter byte addresses, index 0 primary, 1 auxiliary
   localparam logic [1:0][7:0] A_RES_HI = {8'hdb, 8'hd9};
   localparam logic [1:0][7:0] A_RES_LO = {8'hdc, 8'hda};
   localparam logic [1:0][7:0] A_OFF_HI = {8'he3, 8'he1};
   localparam logic [1:0][7:0] A_OFF_LO = {8'he4, 8'he2};
   localparam logic [1:0][7:0] A_GN_HI = {8'heb, 8'he9};
   localparam logic [1:0][7:0] A_GN_LO = {8'hec, 8'hea};
   // reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [7:0] DECIM_RST = 8'h45;
   localparam logic [15:0] OFF_RST = 16'h8000;
   localparam logic [15:0] GN_RST = 16'h5555;
   localparam logic [15:0] ALL_ONES = 16'hffff;
   // writable bits of the mode register
   localparam logic [7:0] MODE_WMASK = 8'h37;
   // field positions
   localparam int M_EN0 = 5;
   localparam int M_EN1 = 4;
   localparam int ST_PRIMARY_READY_FLAG = 7;
   localparam int ST_CAL = 5;
   localparam int ST_NOREF = 4;
   localparam int ST_PRIMARY_CLAMP_ERROR = 3;
   typedef enum logic [2:0] {
      DASM_MD_PWRDN = 3'b000,
      DASM_MD_IDLE = 3'b001,
      DASM_MD_SINGLE = 3'b010,
      DASM_MD_CONT = 3'b011,
      DASM_MD_ZCAL = 3'b100
   } dasm_md_t;
   // one converter's report of a finished cycle
   typedef struct packed {
      logic conv_done;
      logic cal_done;
      logic clamped;
      logic cal_fault;
      logic [15:0] data;
   } dasm_ev_t;
   // steering handed to one converter
   typedef struct packed {
      logic enable;
      logic [2:0] mode;
      logic hold_reset;
      logic start;
      logic [7:0] decim;
      logic [15:0] offset;
      logic [15:0] gain;
   } dasm_ctrl_t;
endpackage

// ### dasm_core.sv
// core-side model that drives the special function register bus
`timescale 1ns/1ps
module dasm_core (
   input wire logic ref_clk,
   output logic [7:0] sfr_addr,
   output logic sfr_wr,
   output logic sfr_rd,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata_q
);
   // bus idles low; address flips when idle, and data too after a write, so stale values never match
   initial begin
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
   end
   // one write; an idle edge first, so back-to-back calls never retoggle the strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1 sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge ref_clk);
      #1 sfr_wr = 1'b0;
      sfr_addr = ~a;
      sfr_wdata = ~d;
   endtask
   // one read; data is registered at the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #1 sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge ref_clk);
      #1 sfr_rd = 1'b0;
      sfr_addr = ~a;
      d = sfr_rdata_q;
   endtask
endmodule

// ### dasm_regs_test.sv
// self-checking bench for the converter status and mode registers
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module dasm_regs_test;
   logic ref_clk;
   logic rstn;
   logic [7:0] sfr_addr;
   logic sfr_wr;
   logic sfr_rd;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata_q;
   dasm_pkg::dasm_ev_t [1:0] conv_ev;
   logic ref_missing;
   logic ext_ref_sel;
   dasm_pkg::dasm_ctrl_t [1:0] conv_ctrl;
   int errors = 0;
   int n_compared = 0;
   dasm_regs dasm_regs_i (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
      .conv_ev(conv_ev), .ref_missing(ref_missing), .ext_ref_sel(ext_ref_sel),
      .conv_ctrl(conv_ctrl));
   dasm_core dasm_core_i (.ref_clk(ref_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q));
   // 20 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      dasm_core_i.rd(a, v);
      `CHK(v, e)
   endtask
   // hi and lo bytes are independent, so each is checked on its own
   task automatic r16(input logic [7:0] h, input logic [7:0] l, input logic [15:0] e);
      rchk(h, e[15:8]);
      rchk(l, e[7:0]);
   endtask
   // one report pulse after an idle edge; flt is a clamp on conversions, a fault on calibrations
   task automatic ev(input int i, input logic cal, input logic flt, input logic [15:0] d);
      @(posedge ref_clk);
      #1 conv_ev[i] = {~cal, cal, ~cal & flt, cal & flt, d};
      @(posedge ref_clk);
      #1 conv_ev[i] = '0;
   endtask
   task automatic t_reset();
      rchk(dasm_pkg::A_MODE, 8'h00);
      rchk(dasm_pkg::A_STAT, 8'h00);
      r16(dasm_pkg::A_OFF_HI[1], dasm_pkg::A_OFF_LO[1], 16'h8000);
      r16(dasm_pkg::A_GN_HI[0], dasm_pkg::A_GN_LO[0], 16'h5555);
      $display("reset test done");
   endtask
   task automatic t_single();
      dasm_core_i.wr(dasm_pkg::A_MODE, 8'h22);
      `CHK(conv_ctrl[0].start, 1'b1)
      ev(0, 1'b0, 1'b0, 16'h1234);
      rchk(dasm_pkg::A_MODE, 8'h20);
      rchk(dasm_pkg::A_STAT, 8'h80);
      r16(dasm_pkg::A_RES_HI[0], dasm_pkg::A_RES_LO[0], 16'h1234);
      dasm_core_i.wr(dasm_pkg::A_STAT, 8'h00);
      rchk(dasm_pkg::A_STAT, 8'h00);
      $display("single test done");
   endtask
   // second results must be dropped while ready flags stand
   task automatic t_cont();
      dasm_core_i.wr(dasm_pkg::A_MODE, 8'h33);
      ev(0, 1'b0, 1'b0, 16'h0a0a);
      ev(1, 1'b0, 1'b0, 16'h4444);
      rchk(dasm_pkg::A_STAT, 8'hc0);
      ev(0, 1'b0, 1'b0, 16'h5678);
      ev(1, 1'b0, 1'b0, 16'h9999);
      r16(dasm_pkg::A_RES_HI[0], dasm_pkg::A_RES_LO[0], 16'h0a0a);
      r16(dasm_pkg::A_RES_HI[1], dasm_pkg::A_RES_LO[1], 16'h4444);
      dasm_core_i.wr(dasm_pkg::A_STAT, 8'h40);
      rchk(dasm_pkg::A_STAT, 8'h40);
      ev(0, 1'b0, 1'b1, 16'h5678);
      r16(dasm_pkg::A_RES_HI[0], dasm_pkg::A_RES_LO[0], 16'h5678);
      rchk(dasm_pkg::A_STAT, 8'hc8);
      dasm_core_i.wr(dasm_pkg::A_MODE, 8'h00);
      dasm_core_i.wr(dasm_pkg::A_STAT, 8'h00);
      $display("continuous test done");
   endtask
   task automatic t_ref();
      ref_missing = 1'b1;
      dasm_core_i.wr(dasm_pkg::A_MODE, 8'h23);
      ev(0, 1'b0, 1'b0, 16'h1234);
      r16(dasm_pkg::A_RES_HI[0], dasm_pkg::A_RES_LO[0], 16'hffff);
      rchk(dasm_pkg::A_STAT, 8'h98);
      dasm_core_i.wr(dasm_pkg::A_MODE, 8'h23);
      rchk(dasm_pkg::A_STAT, 8'h10);
      ref_missing = 1'b0;
      @(posedge ref_clk);
      rchk(dasm_pkg::A_STAT, 8'h00);
      dasm_core_i.wr(dasm_pkg::A_MODE, 8'h00);
      $display("reference test done");
   endtask
   // a failed calibration must leave the old offset in place
   task automatic t_cal();
      dasm_core_i.wr(dasm_pkg::A_MODE, 8'h24);
      ev(0, 1'b1, 1'b0, 16'h1111);
      rchk(dasm_pkg::A_STAT, 8'ha0);
      r16(dasm_pkg::A_OFF_HI[0], dasm_pkg::A_OFF_LO[0], 16'h1111);
      dasm_core_i.wr(dasm_pkg::A_MODE, 8'h14);
      ev(1, 1'b1, 1'b1, 16'h2222);
      r16(dasm_pkg::A_OFF_HI[1], dasm_pkg::A_OFF_LO[1], 16'h8000);
      rchk(dasm_pkg::A_STAT, 8'he4);
      dasm_core_i.wr(dasm_pkg::A_STAT, 8'h00);
      rchk(dasm_pkg::A_STAT, 8'h24);
      $display("calibration test done");
   endtask
   task automatic t_resv();
      dasm_core_i.wr(dasm_pkg::A_MODE, 8'hff);
      rchk(dasm_pkg::A_MODE, 8'h37);
      dasm_core_i.wr(dasm_pkg::A_STAT, 8'h03);
      rchk(dasm_pkg::A_STAT, 8'h24);
      dasm_core_i.wr(dasm_pkg::A_MODE, 8'h21);
      dasm_core_i.wr(dasm_pkg::A_DECIM, 8'h12);
      @(posedge ref_clk);
      #1 `CHK(conv_ctrl[0].hold_reset, 1'b1)
      `CHK(conv_ctrl[1].enable, 1'b0)
      `CHK(conv_ctrl[1].decim, 8'h12)
      `CHK(conv_ctrl[0].mode, 3'h1)
      `CHK(conv_ctrl[0].offset, 16'h1111)
      dasm_core_i.wr(dasm_pkg::A_GN_HI[1], 8'h9a);
      dasm_core_i.wr(dasm_pkg::A_GN_LO[1], 8'hbc);
      `CHK(conv_ctrl[1].gain, 16'h9abc)
      rchk(8'h80, 8'h00);
      $display("reserved test done");
   endtask
   // watchdog, far beyond the roughly 130 cycles the tests need
   initial begin
      #100000;
      errors++;
      finish_test();
   end
   initial begin
      rstn = 1'b0;
      conv_ev = '0;
      ref_missing = 1'b0;
      ext_ref_sel = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 rstn = 1'b1;
      t_reset();
      t_single();
      t_cont();
      t_ref();
      t_cal();
      t_resv();
      finish_test();
   end
endmodule
